// ==== src/periodic_tick_timer.sv ====
`timescale 1ns/1ps
`include "tick_timer_regs.svh"
// How it works
// - 24-bit down-counter, one step per enabled clock
// - At zero, reload value and raise tick request
// - Bit 16 flag set at zero, read clears
// - Bit 2 selects system clock; reset 0 (here the bit is only stored; counting always runs on the system clock)
// - Bit 1 lets zero event raise exception
// - Bit 0 starts and stops the counter
// - Reload field bits 23:0, upper bits reserved
// - Current value write clears count and flag
// - Timer events never act as wake-up source
module periodic_tick_timer #(
	parameter int COUNT_WIDTH = 24
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Register port
	input tick_timer_pkg::bus_req_s i_bus,
	output logic [31:0] o_rdata,
	// Events
	output logic o_tick_req,
	output logic o_irq,
	output logic o_wake
);
	import tick_timer_pkg::*;

	// ==========================================================
	// Register state
	ctrl_s ctrl_ff;
	count_t reload_ff;
	count_t count_ff;
	logic flag_ff;
	logic irq_status_ff;
	logic irq_mask_ff;
	logic tick_req_ff;
	logic irq_ff;
	logic [31:0] rdata_ff;

	logic wr_ctrl;
	logic wr_reload;
	logic wr_current;
	logic wr_status;
	logic wr_mask;
	logic rd_ctrl;
	logic counting;
	logic at_zero;
	logic zero_event;
	logic [31:0] nxt_rdata;
	count_t nxt_count;
	ctrl_s nxt_ctrl;
	count_t nxt_reload;
	logic nxt_flag;
	logic nxt_tick_req;
	logic nxt_irq_status;
	logic nxt_irq_mask;
	logic nxt_irq;
	logic wake_ff;
	// Read views of each register word, zero outside the stored fields
	logic [31:0] ctrl_word;
	logic [31:0] reload_word;
	logic [31:0] current_word;
	logic [31:0] status_word;
	logic [31:0] mask_word;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
		hit = (a == target);
	endfunction : hit

	// One step of the down-counter; wrapping happens only through the reload
	function automatic count_t step_down(input count_t value);
		step_down = value - count_t'(1);
	endfunction : step_down

	// Places a one-bit field at the bottom of an otherwise empty word
	function automatic logic [31:0] low_bit_word(input logic value);
		low_bit_word = {31'h0000_0000, value};
	endfunction : low_bit_word

	// Builds the control and status word as software reads it
	function automatic logic [31:0] pack_ctrl(input logic flag, input ctrl_s c);
		pack_ctrl = 32'h0000_0000;
		pack_ctrl[`TICK_FLAG_BIT] = flag;
		pack_ctrl[`TICK_CLKSEL_BIT] = c.clk_sel;
		pack_ctrl[`TICK_IRQ_EN_BIT] = c.irq_en;
		pack_ctrl[`TICK_ENABLE_BIT] = c.enable;
	endfunction : pack_ctrl

	// ==========================================================
	// Address decode
	always_comb begin
		wr_ctrl = 1'b0;
		wr_reload = 1'b0;
		wr_current = 1'b0;
		wr_status = 1'b0;
		wr_mask = 1'b0;
		if (hit(i_bus.addr, `TICK_CTRL_ADDR)) begin
			wr_ctrl = i_bus.wr;
		end else if (hit(i_bus.addr, `TICK_RELOAD_ADDR)) begin
			wr_reload = i_bus.wr;
		end else if (hit(i_bus.addr, `TICK_CURRENT_ADDR)) begin
			wr_current = i_bus.wr;
		end else if (hit(i_bus.addr, `TICK_IRQ_STATUS_ADDR)) begin
			wr_status = i_bus.wr;
		end else if (hit(i_bus.addr, `TICK_IRQ_MASK_ADDR)) begin
			wr_mask = i_bus.wr;
		end
	end

	assign rd_ctrl = i_bus.rd && hit(i_bus.addr, `TICK_CTRL_ADDR);

	// ==========================================================
	// Counter
	// Only the system clock exists here, so the select bit is stored but
	// counting does not wait for it; the reserved setting counts the same.
	assign counting = ctrl_ff.enable;
	assign at_zero = (count_ff == '0);
	// A zero produced by software clearing the count is not an event, and a
	// clear that lands on the last step swallows that step's event too.
	assign zero_event = counting && !wr_current && (count_ff == count_t'(1));

	// A count clear beats the enabled step. The step into zero is the
	// event; the following cycle loads the reload value, so one period
	// lasts reload plus one cycles.
	always_comb begin
		nxt_count = count_ff;
		if (wr_current) begin
			nxt_count = '0;
		end else if (counting) begin
			if (at_zero) begin
				nxt_count = reload_ff;
			end else begin
				nxt_count = step_down(count_ff);
			end
		end else begin
			nxt_count = count_ff;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			count_ff <= `TICK_COUNT_RESET;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// ==========================================================
	// Control and reload
	// Only the three control bits are stored; all other bits except the bit 16 flag read as zero.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl.clk_sel = i_bus.wdata[`TICK_CLKSEL_BIT];
			nxt_ctrl.irq_en = i_bus.wdata[`TICK_IRQ_EN_BIT];
			nxt_ctrl.enable = i_bus.wdata[`TICK_ENABLE_BIT];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			ctrl_ff <= `TICK_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Reset value is undefined for software; a zero keeps simulation clean.
	// A new reload value takes effect at the next wrap, not at once.
	always_comb begin
		nxt_reload = reload_ff;
		if (wr_reload) begin
			nxt_reload = i_bus.wdata[23:0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			reload_ff <= `TICK_RELOAD_RESET;
		end else begin
			reload_ff <= nxt_reload;
		end
	end

	// ==========================================================
	// Zero-reached flag
	// The zero event wins over a read clear so no tick is lost; the read
	// that loses still returns the old flag, and the next read sees it set.
	always_comb begin
		nxt_flag = flag_ff;
		if (zero_event) begin
			nxt_flag = 1'b1;
		end else if (rd_ctrl || wr_current) begin
			nxt_flag = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			flag_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	// ==========================================================
	// Exception request and interrupt
	// The request is a one-cycle pulse, one cycle after the step into zero
	always_comb begin
		nxt_tick_req = 1'b0;
		if (zero_event && ctrl_ff.irq_en) begin
			nxt_tick_req = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			tick_req_ff <= 1'b0;
		end else begin
			tick_req_ff <= nxt_tick_req;
		end
	end

	// Sticky status: a new event beats a clear in the same cycle
	always_comb begin
		nxt_irq_status = irq_status_ff;
		if (zero_event && ctrl_ff.irq_en) begin
			nxt_irq_status = 1'b1;
		end else if (wr_status && i_bus.wdata[0]) begin
			nxt_irq_status = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			irq_status_ff <= `TICK_IRQ_RESET;
		end else begin
			irq_status_ff <= nxt_irq_status;
		end
	end

	always_comb begin
		nxt_irq_mask = irq_mask_ff;
		if (wr_mask) begin
			nxt_irq_mask = i_bus.wdata[0];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			irq_mask_ff <= `TICK_IRQ_RESET;
		end else begin
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	// Level output; costs one cycle of latency so that it leaves a flop
	always_comb begin
		nxt_irq = 1'b0;
		if (irq_status_ff && irq_mask_ff) begin
			nxt_irq = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// ==========================================================
	// Register words as software sees them
	assign ctrl_word = pack_ctrl(flag_ff, ctrl_ff);
	assign reload_word = {8'h00, reload_ff};
	assign current_word = {8'h00, count_ff};
	assign status_word = low_bit_word(irq_status_ff);
	assign mask_word = low_bit_word(irq_mask_ff);

	// ==========================================================
	// Read data, valid the cycle after the read strobe
	// Unmapped addresses read as zero rather than stalling the bus.
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (hit(i_bus.addr, `TICK_CTRL_ADDR)) begin
			nxt_rdata = ctrl_word;
		end else if (hit(i_bus.addr, `TICK_RELOAD_ADDR)) begin
			nxt_rdata = reload_word;
		end else if (hit(i_bus.addr, `TICK_CURRENT_ADDR)) begin
			nxt_rdata = current_word;
		end else if (hit(i_bus.addr, `TICK_IRQ_STATUS_ADDR)) begin
			nxt_rdata = status_word;
		end else if (hit(i_bus.addr, `TICK_IRQ_MASK_ADDR)) begin
			nxt_rdata = mask_word;
		end
	end

	// Data stands for one cycle only, then returns to zero
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			rdata_ff <= 32'h0000_0000;
		end else if (i_bus.rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Standby wake
	// Held low by design: the timer must never pull the part out of
	// standby, so no event path reaches this flop.
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			wake_ff <= 1'b0;
		end else begin
			wake_ff <= 1'b0;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_tick_req = tick_req_ff;
	assign o_irq = irq_ff;
	assign o_wake = wake_ff;

endmodule : periodic_tick_timer

// ==== src/tick_timer_pkg.sv ====
package tick_timer_pkg;

	typedef logic [23:0] count_t;

	// Software command port
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} bus_req_s;

	// Control bits held by the control and status word
	typedef struct packed {
		logic clk_sel;
		logic irq_en;
		logic enable;
	} ctrl_s;

endpackage : tick_timer_pkg

// ==== src/tick_timer_regs.svh ====
`ifndef TICK_TIMER_REGS_SVH
`define TICK_TIMER_REGS_SVH

// Byte addresses of the three registers
`define TICK_CTRL_ADDR 32'he000_e010
`define TICK_RELOAD_ADDR 32'he000_e014
`define TICK_CURRENT_ADDR 32'he000_e018
// Interrupt status and mask, placed just above the timer words
`define TICK_IRQ_STATUS_ADDR 32'he000_e01c
`define TICK_IRQ_MASK_ADDR 32'he000_e020

// Field positions in the control and status word
`define TICK_ENABLE_BIT 0
`define TICK_IRQ_EN_BIT 1
`define TICK_CLKSEL_BIT 2
`define TICK_FLAG_BIT 16

// Reset values
`define TICK_CTRL_RESET 3'h0
`define TICK_COUNT_RESET 24'h00_0000
`define TICK_RELOAD_RESET 24'h00_0000
`define TICK_IRQ_RESET 1'b0

`endif

// ==== verif/periodic_tick_timer_tb.sv ====
`timescale 1ns/1ps
`include "tick_timer_regs.svh"
module periodic_tick_timer_tb;
	import tick_timer_pkg::*;
	logic clk = 0;
	logic rst = 1;
	bus_req_s bus = '0;
	logic [31:0] rdata;
	logic tick, irq, wake;
	int n_fail = 0;
	int checked = 0;
	int seed = 32'ha593;
	int p, k;
	logic [31:0] r;
	periodic_tick_timer u_periodic_tick_timer (.i_core_clk(clk), .i_reset(rst), .i_bus(bus),
		.o_rdata(rdata), .o_tick_req(tick), .o_irq(irq), .o_wake(wake));
	initial forever #50 clk = ~clk;
	// ========
	// Helpers
	function automatic logic [31:0] ctl_exp(logic f, logic [2:0] c);
		return {15'h0000, f, 13'h0000, c};
	endfunction : ctl_exp
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic wr(logic [31:0] a, logic [31:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus <= '0;
	endtask : wr
	task automatic rd(string s, logic [31:0] a, logic [31:0] e);
		@(posedge clk) bus <= '{a, '0, 1'b0, 1'b1};
		@(posedge clk) bus <= '0;
		#1 chk(s, e, rdata);
	endtask : rd
	// Cycles up to the next tick request
	task automatic gap();
		p = 0;
		do begin
			@(posedge clk);
			#1 p++;
		end while (tick !== 1'b1 && p < 300);
	endtask : gap
	task automatic cnt(int n);
		k = 0;
		repeat (n) begin
			@(posedge clk);
			#1 k += tick;
		end
	endtask : cnt
	task test_done();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// Whole run is a few hundred cycles, so this is generous
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		test_done();
	end
	// ========
	// Scenarios
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		rd("ctl", `TICK_CTRL_ADDR, ctl_exp(0, 0));
		rd("cur", `TICK_CURRENT_ADDR, 0);
		wr(32'he000_e024, '1);
		rd("hole", 32'he000_e024, 0);
		repeat (4) begin
			r = $random(seed);
			wr(`TICK_RELOAD_ADDR, r);
			rd("rld", `TICK_RELOAD_ADDR, {8'h00, r[23:0]});
			wr(`TICK_CTRL_ADDR, r & 32'hffff_fffe);
			rd("ctl", `TICK_CTRL_ADDR, ctl_exp(0, {r[2:1], 1'b0}));
		end
		r = 40 + {$random(seed)} % 8;
		wr(`TICK_CTRL_ADDR, 0);
		wr(`TICK_RELOAD_ADDR, r);
		wr(`TICK_CURRENT_ADDR, r);
		wr(`TICK_IRQ_MASK_ADDR, 1);
		wr(`TICK_CTRL_ADDR, 7);
		gap();
		gap();
		chk("period", r + 1, p);
		rd("ctl", `TICK_CTRL_ADDR, ctl_exp(1, 7));
		rd("ctl", `TICK_CTRL_ADDR, ctl_exp(0, 7));
		chk("irq", 1, irq);
		wr(`TICK_IRQ_MASK_ADDR, 0);
		@(posedge clk);
		#1 chk("irq", 0, irq);
		wr(`TICK_IRQ_STATUS_ADDR, 1);
		rd("stat", `TICK_IRQ_STATUS_ADDR, 0);
		wr(`TICK_IRQ_MASK_ADDR, 1);
		gap();
		repeat (2) @(posedge clk);
		#1 chk("irq", 1, irq);
		wr(`TICK_CTRL_ADDR, 5);
		cnt(2 * r);
		chk("ticks", 0, k);
		wr(`TICK_CURRENT_ADDR, r);
		rd("ctl", `TICK_CTRL_ADDR, ctl_exp(0, 5));
		wr(`TICK_CTRL_ADDR, 6);
		cnt(r);
		chk("ticks", 0, k);
		rd("cur", `TICK_CURRENT_ADDR, r - 3);
		test_done();
	end
endmodule : periodic_tick_timer_tb

// ==== verif/tick_timer_monitor.sv ====
`timescale 1ns/1ps
`include "tick_timer_regs.svh"
module tick_timer_monitor (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// Watched ports
	input tick_timer_pkg::bus_req_s i_bus,
	input wire logic [31:0] o_rdata,
	input wire logic o_tick_req,
	input wire logic o_irq,
	input wire logic o_wake
);
	import tick_timer_pkg::*;
	// ========
	// Checks
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (i_reset);
	sequence s_rd(logic [31:0] a);
		i_bus.rd && i_bus.addr == a;
	endsequence
	a_no_wake: assert property (!o_wake)
		else $error("wake raised");
	a_rd_idle: assert property (!i_bus.rd |=> o_rdata == '0)
		else $error("read data not idle");
	a_ctrl_form: assert property (s_rd(`TICK_CTRL_ADDR) |=> (o_rdata & 32'hfffe_fff8) == '0)
		else $error("control word reserved bits set");
	a_rld_form: assert property (s_rd(`TICK_RELOAD_ADDR) |=> o_rdata[31:24] == 8'h00)
		else $error("reload upper bits set");
	// A count clear on the last step must swallow that step's request
	a_cvr_quiet: assert property (i_bus.wr && i_bus.addr == `TICK_CURRENT_ADDR |=> !o_tick_req)
		else $error("tick after count clear");
	a_tick_pulse: assert property (o_tick_req |=> !o_tick_req)
		else $error("tick request too long");
	a_hole_zero: assert property (i_bus.rd && i_bus.addr[31:8] != 24'he0_00e0 |=> o_rdata == '0)
		else $error("unmapped read not zero");
	a_reset_quiet: assert property ($fell(i_reset) |-> !o_tick_req && !o_irq)
		else $error("event right after reset");
	a_stat_form: assert property (s_rd(`TICK_IRQ_STATUS_ADDR) |=> o_rdata[31:1] == '0)
		else $error("status upper bits set");
endmodule : tick_timer_monitor
bind periodic_tick_timer tick_timer_monitor u_tick_timer_monitor (.i_core_clk(i_core_clk),
	.i_reset(i_reset), .i_bus(i_bus), .o_rdata(o_rdata), .o_tick_req(o_tick_req),
	.o_irq(o_irq), .o_wake(o_wake));
